// ===== hw/rgb_regs_pkg.sv
// Constants and helpers shared by the RGB LED control register bank
package rgb_regs_pkg;
	localparam logic [7:0] ADDR_LOW_BITS = 8'h00;
	localparam logic [7:0] ADDR_GREEN_HI = 8'h01;
	localparam logic [7:0] ADDR_BLUE_HI = 8'h02;
	localparam logic [7:0] ADDR_RED_HI = 8'h03;
	localparam logic [7:0] ADDR_FAULT_RPT = 8'h05;
	localparam logic [7:0] ADDR_DELAY = 8'h06;
	localparam logic [7:0] ADDR_FAULT = 8'h07;

	localparam logic [5:0] RST_LOW_BITS = 6'h3f;
	localparam logic [7:0] RST_GREEN_HI = 8'hff;
	localparam logic [7:0] RST_BLUE_HI = 8'hff;
	localparam logic [7:0] RST_RED_HI = 8'hff;
	localparam logic RST_FAULT_RPT = 1'b1;
	localparam logic [5:0] RST_DELAY = 6'h3f;

	localparam int LOW_RED_POS = 4;
	localparam int LOW_BLUE_POS = 2;
	localparam int LOW_GREEN_POS = 0;
	localparam int DLY_RED_POS = 6;
	localparam int DLY_BLUE_POS = 3;
	localparam int DLY_GREEN_POS = 0;
	localparam int DLY_FILL_HI_POS = 5;
	localparam int DLY_FILL_LO_POS = 2;
	localparam int FLT_GREEN_OPEN_POS = 7;
	localparam int FLT_GREEN_SHORT_POS = 6;
	localparam int FLT_BLUE_OPEN_POS = 4;
	localparam int FLT_BLUE_SHORT_POS = 3;
	localparam int FLT_RED_OPEN_POS = 1;
	localparam int FLT_RED_SHORT_POS = 0;

	localparam int CLK_PERIOD_NS = 10;
	localparam int DLY_BASE_US = 5;
	localparam int DLY_STEP_US = 10;
	localparam int TIMER_W = 12;
	localparam logic [1:0] FAULT_CONFIRM_EDGES = 2'h3;

	// Delay code to clock cycles: 5, 15, 25, 35 us
	function automatic logic [TIMER_W-1:0] dly_cycles(input logic [1:0] code);
		int us;
		us = DLY_BASE_US + DLY_STEP_US * int'(code);
		return TIMER_W'((us * 1000) / CLK_PERIOD_NS);
	endfunction
endpackage

// ===== hw/rgb_channel.sv
// One colour channel: pin synchronisers, transition delay, fault confirmation
`timescale 1ns/1ps
module rgb_channel
	import rgb_regs_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic ctrl_pin,
	input wire logic open_suspect,
	input wire logic short_suspect,
	input wire logic [1:0] delay_code,
	input wire logic report_en,
	output logic led_enable,
	output logic open_flag,
	output logic short_flag
);
	typedef struct packed {
		logic [2:0] ctrl_sync;
		logic [2:0] open_sync;
		logic [2:0] short_sync;
		logic ctrl_f;
		logic open_f;
		logic short_f;
		logic ctrl_prev;
		logic [TIMER_W-1:0] timer;
		logic led_en;
		logic [1:0] open_cnt;
		logic [1:0] short_cnt;
		logic open_flag;
		logic short_flag;
	} rgb_chan_state_type;

	rgb_chan_state_type q, d;
	logic rise, fall;

	always_comb
	begin
		d = q;
		d.ctrl_sync = {q.ctrl_sync[1:0], ctrl_pin};
		d.open_sync = {q.open_sync[1:0], open_suspect};
		d.short_sync = {q.short_sync[1:0], short_suspect};
		if (q.ctrl_sync[1] == q.ctrl_sync[2])
			d.ctrl_f = q.ctrl_sync[2];
		if (q.open_sync[1] == q.open_sync[2])
			d.open_f = q.open_sync[2];
		if (q.short_sync[1] == q.short_sync[2])
			d.short_f = q.short_sync[2];
		d.ctrl_prev = q.ctrl_f;
		rise = q.ctrl_f & ~q.ctrl_prev;
		fall = ~q.ctrl_f & q.ctrl_prev;
		// Hold the LED off for the programmed delay after its control rises
		if (!q.ctrl_f)
		begin
			d.timer = '0;
			d.led_en = 1'b0;
		end
		else if (rise)
		begin
			d.timer = dly_cycles(delay_code);
			d.led_en = 1'b0;
		end
		else if (q.timer != '0)
		begin
			d.timer = q.timer - TIMER_W'(1);
			if (q.timer == TIMER_W'(1))
				d.led_en = 1'b1;
		end
		// Faults confirmed on consecutive falling edges of the control
		if (!report_en)
		begin
			d.open_cnt = 2'h0;
			d.short_cnt = 2'h0;
			d.open_flag = 1'b0;
			d.short_flag = 1'b0;
		end
		else if (fall)
		begin
			if (!q.open_f)
				d.open_cnt = 2'h0;
			else if (q.open_cnt == FAULT_CONFIRM_EDGES - 2'h1)
				d.open_flag = 1'b1;
			else
				d.open_cnt = q.open_cnt + 2'h1;
			if (!q.short_f)
				d.short_cnt = 2'h0;
			else if (q.short_cnt == FAULT_CONFIRM_EDGES - 2'h1)
				d.short_flag = 1'b1;
			else
				d.short_cnt = q.short_cnt + 2'h1;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			q <= '0;
		else
			q <= d;
	end

	assign led_enable = q.led_en;
	assign open_flag = q.open_flag;
	assign short_flag = q.short_flag;
endmodule

// ===== hw/rgb_led_control_regs.sv
// Control register bank of the sequential RGB LED driver
// Overview of operation
// - Each colour holds its own 10-bit current code, 1024 levels.
// - Current code maps linearly from minimum current to reference current.
// - Low register: red code bits 5:4, blue 3:2, green 1:0.
// - Registers 01h, 02h, 03h hold code bits 9:2 of green, blue, red.
// - Low register bits 7:6 and enable register bits 7:1 read zero.
// - Enable bit 0 set allows fault reporting; clear keeps fault output low.
// - Next LED turns on only after its programmed transition delay.
// - Delay selectable 5 to 35 us in 10 us steps, 35 us default.
// - Delay register: red code 7:6, blue 4:3, green 1:0.
// - Delay register bits 5 and 2 always read one.
// - Fault status register 07h is read-only; writes leave it unchanged.
// - A write takes effect at the final acknowledge of the write transfer.
// - Writing zero to the enable bit clears fault status and output.
// - Fault latches after suspect seen at 3 consecutive control falling edges.
`timescale 1ns/1ps
module rgb_led_control_regs
	import rgb_regs_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic red_ctrl,
	input wire logic green_ctrl,
	input wire logic blue_ctrl,
	input wire logic red_open_suspect,
	input wire logic green_open_suspect,
	input wire logic blue_open_suspect,
	input wire logic red_short_suspect,
	input wire logic green_short_suspect,
	input wire logic blue_short_suspect,
	output logic [9:0] red_current_code,
	output logic [9:0] green_current_code,
	output logic [9:0] blue_current_code,
	output logic red_led_enable,
	output logic green_led_enable,
	output logic blue_led_enable,
	output logic fault_out
);
	typedef struct packed {
		logic [5:0] low_bits;
		logic [7:0] green_hi;
		logic [7:0] blue_hi;
		logic [7:0] red_hi;
		logic report_en;
		logic [1:0] red_transition_delay;
		logic [1:0] blue_transition_delay;
		logic [1:0] green_transition_delay;
		logic [7:0] rd_data;
		logic [9:0] red_code;
		logic [9:0] green_code;
		logic [9:0] blue_code;
		logic fault;
	} rgb_regs_state_type;

	rgb_regs_state_type q, d;

	// Per-channel wires, index 0 green, 1 blue, 2 red
	logic [2:0] ctrl_pins;
	logic [2:0] open_pins;
	logic [2:0] short_pins;
	logic [5:0] chan_delay;
	logic [2:0] led_en;
	logic [2:0] open_flags;
	logic [2:0] short_flags;
	logic [7:0] led_fault_status;

	assign ctrl_pins = {red_ctrl, blue_ctrl, green_ctrl};
	assign open_pins = {red_open_suspect, blue_open_suspect, green_open_suspect};
	assign short_pins = {red_short_suspect, blue_short_suspect, green_short_suspect};
	assign chan_delay = {q.red_transition_delay, q.blue_transition_delay,
		q.green_transition_delay};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_chan
			rgb_channel u_chan (
				.mclk(mclk),
				.sys_rst(sys_rst),
				.ctrl_pin(ctrl_pins[gi]),
				.open_suspect(open_pins[gi]),
				.short_suspect(short_pins[gi]),
				.delay_code(chan_delay[2*gi +: 2]),
				.report_en(q.report_en),
				.led_enable(led_en[gi]),
				.open_flag(open_flags[gi]),
				.short_flag(short_flags[gi])
			);
		end
	endgenerate

	// Fault status layout, reserved bits zero
	always_comb
	begin
		led_fault_status = 8'h00;
		led_fault_status[FLT_GREEN_OPEN_POS] = open_flags[0];
		led_fault_status[FLT_GREEN_SHORT_POS] = short_flags[0];
		led_fault_status[FLT_BLUE_OPEN_POS] = open_flags[1];
		led_fault_status[FLT_BLUE_SHORT_POS] = short_flags[1];
		led_fault_status[FLT_RED_OPEN_POS] = open_flags[2];
		led_fault_status[FLT_RED_SHORT_POS] = short_flags[2];
	end

	always_comb
	begin
		d = q;
		// Writes arrive on the final acknowledge edge of the transfer
		if (reg_wr)
		begin
			case (reg_addr)
				ADDR_LOW_BITS:
					d.low_bits = reg_wdata[5:0];
				ADDR_GREEN_HI:
					d.green_hi = reg_wdata;
				ADDR_BLUE_HI:
					d.blue_hi = reg_wdata;
				ADDR_RED_HI:
					d.red_hi = reg_wdata;
				ADDR_FAULT_RPT:
					d.report_en = reg_wdata[0];
				ADDR_DELAY:
				begin
					d.red_transition_delay = reg_wdata[DLY_RED_POS +: 2];
					d.blue_transition_delay = reg_wdata[DLY_BLUE_POS +: 2];
					d.green_transition_delay = reg_wdata[DLY_GREEN_POS +: 2];
				end
				default:
					d.low_bits = q.low_bits;
			endcase
		end
		// Read data captured on the read strobe
		if (reg_rd)
		begin
			case (reg_addr)
				ADDR_LOW_BITS:
					d.rd_data = {2'b00, q.low_bits};
				ADDR_GREEN_HI:
					d.rd_data = q.green_hi;
				ADDR_BLUE_HI:
					d.rd_data = q.blue_hi;
				ADDR_RED_HI:
					d.rd_data = q.red_hi;
				ADDR_FAULT_RPT:
					d.rd_data = {7'h00, q.report_en};
				ADDR_DELAY:
				begin
					d.rd_data = 8'h00;
					d.rd_data[DLY_RED_POS +: 2] = q.red_transition_delay;
					d.rd_data[DLY_FILL_HI_POS] = 1'b1;
					d.rd_data[DLY_BLUE_POS +: 2] = q.blue_transition_delay;
					d.rd_data[DLY_FILL_LO_POS] = 1'b1;
					d.rd_data[DLY_GREEN_POS +: 2] = q.green_transition_delay;
				end
				ADDR_FAULT:
					d.rd_data = led_fault_status;
				default:
					d.rd_data = 8'h00;
			endcase
		end
		// Full 10-bit codes for the linear current DACs
		d.red_code = {q.red_hi, q.low_bits[LOW_RED_POS +: 2]};
		d.green_code = {q.green_hi, q.low_bits[LOW_GREEN_POS +: 2]};
		d.blue_code = {q.blue_hi, q.low_bits[LOW_BLUE_POS +: 2]};
		d.fault = q.report_en & ((|open_flags) | (|short_flags));
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			q <= '0;
			q.low_bits <= RST_LOW_BITS;
			q.green_hi <= RST_GREEN_HI;
			q.blue_hi <= RST_BLUE_HI;
			q.red_hi <= RST_RED_HI;
			q.report_en <= RST_FAULT_RPT;
			q.red_transition_delay <= RST_DELAY[DLY_RED_POS-1 -: 2];
			q.blue_transition_delay <= RST_DELAY[3:2];
			q.green_transition_delay <= RST_DELAY[1:0];
		end
		else
			q <= d;
	end

	assign reg_rdata = q.rd_data;
	assign red_current_code = q.red_code;
	assign green_current_code = q.green_code;
	assign blue_current_code = q.blue_code;
	assign red_led_enable = led_en[2];
	assign green_led_enable = led_en[0];
	assign blue_led_enable = led_en[1];
	assign fault_out = q.fault;
endmodule

// ===== bench/rgb_led_model.sv
// Control-pin model of the sequencing host on the far side
`timescale 1ns/1ps
module rgb_led_model #(parameter int HI = 3600)
(
	input wire logic mclk,
	input wire logic [2:0] fire,
	output logic [2:0] ctrl
);
	int cnt [3] = '{0, 0, 0};
	// Pin held high for a fixed span, then driven low again
	always_comb
	begin
		for (int i = 0; i < 3; i++) ctrl[i] = cnt[i] != 0;
	end
	always @(posedge mclk)
	begin
		for (int i = 0; i < 3; i++)
			if (fire[i]) cnt[i] <= HI;
			else if (cnt[i] != 0) cnt[i] <= cnt[i] - 1;
	end
endmodule

// ===== bench/rgb_led_control_regs_properties.sv
// Port checker for the register bank
`timescale 1ns/1ps
module rgb_regs_checker
	import rgb_regs_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic red_ctrl,
	input wire logic [9:0] red_current_code,
	input wire logic [9:0] green_current_code,
	input wire logic red_led_enable,
	input wire logic fault_out
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	sequence s_ctrl_low; !red_ctrl [*8]; endsequence
	property p_low_zero; reg_rd && reg_addr == ADDR_LOW_BITS |=> reg_rdata[7:6] == 2'h0; endproperty
	property p_rpt_zero; reg_rd && reg_addr == ADDR_FAULT_RPT |=> reg_rdata[7:1] == 7'h0; endproperty
	property p_dly_ones; reg_rd && reg_addr == ADDR_DELAY |=> reg_rdata[5] && reg_rdata[2]; endproperty
	property p_unmapped; reg_rd && reg_addr == 8'h04 |=> reg_rdata == 8'h00; endproperty
	property p_red_hi; reg_wr && reg_addr == ADDR_RED_HI
		|-> ##2 red_current_code[9:2] == $past(reg_wdata, 2); endproperty
	property p_grn_lo; reg_wr && reg_addr == ADDR_LOW_BITS
		|-> ##2 green_current_code[1:0] == $past(reg_wdata[1:0], 2); endproperty
	property p_rpt_off; reg_wr && reg_addr == ADDR_FAULT_RPT && !reg_wdata[0]
		|-> ##3 !fault_out [*4]; endproperty
	property p_en_cause; $rose(red_led_enable) |-> $past(red_ctrl, 3); endproperty
	property p_en_drop; s_ctrl_low |-> !red_led_enable; endproperty
	a_low_zero: assert property (p_low_zero)
		else $error("low register top bits not zero");
	a_rpt_zero: assert property (p_rpt_zero)
		else $error("enable register top bits not zero");
	a_dly_ones: assert property (p_dly_ones)
		else $error("delay filler bits not one");
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	a_red_hi: assert property (p_red_hi)
		else $error("red code high bits wrong");
	a_grn_lo: assert property (p_grn_lo)
		else $error("green code low bits wrong");
	a_rpt_off: assert property (p_rpt_off)
		else $error("fault output active while disabled");
	a_en_cause: assert property (p_en_cause)
		else $error("led enable without control");
	a_en_drop: assert property (p_en_drop)
		else $error("led enable after control low");
endmodule
bind rgb_led_control_regs rgb_regs_checker rgb_regs_checker_i (.mclk, .sys_rst, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .red_ctrl, .red_current_code,
	.green_current_code, .red_led_enable, .fault_out);

// ===== bench/rgb_led_control_regs_test.sv
// Self-checking testbench of the register bank
`timescale 1ns/1ps
module rgb_led_control_regs_test;
	import rgb_regs_pkg::*;
	localparam int HI = 3600;
	logic mclk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [2:0] open_s = 3'h0, short_s = 3'h0, en_v;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic [2:0] fire = 3'h0, ctrl;
	logic [9:0] rc, gc, bc;
	logic red_en, ge, be, fault_out;
	int error_cnt = 0, n_tests = 0, n, ex;
	int seen [3], k [3];
	logic [7:0] ra [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07};
	logic [7:0] re [8] = '{8'h3f, 8'hff, 8'hff, 8'hff, 8'h00, 8'h01, 8'hff, 8'h00};
	always #5 mclk = ~mclk;
	rgb_led_model #(.HI(HI)) rgb_led_model_i (.mclk(mclk), .fire(fire), .ctrl(ctrl));
	rgb_led_control_regs rgb_led_control_regs_i (.mclk(mclk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .red_ctrl(ctrl[0]), .green_ctrl(ctrl[1]), .blue_ctrl(ctrl[2]),
		.red_open_suspect(open_s[0]), .green_open_suspect(open_s[1]),
		.blue_open_suspect(open_s[2]), .red_short_suspect(short_s[0]),
		.green_short_suspect(short_s[1]), .blue_short_suspect(short_s[2]),
		.red_current_code(rc), .green_current_code(gc),
		.blue_current_code(bc), .red_led_enable(red_en), .green_led_enable(ge),
		.blue_led_enable(be), .fault_out(fault_out));
	// Enables in model order: 0 red, 1 green, 2 blue
	assign en_v = {be, ge, red_en};
	task chk(input string nm, input logic [9:0] e, input logic [9:0] g);
		n_tests++;
		if (g !== e)
		begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			error_cnt++;
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		@(posedge mclk);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(posedge mclk);
		chk("register read", {2'h0, e}, {2'h0, reg_rdata});
	endtask
	task pulse;
		fire <= 3'h7;
		@(posedge mclk);
		fire <= 3'h0;
		repeat (HI + 50) @(posedge mclk);
	endtask
	task conclude;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		repeat (100000) @(posedge mclk);
		error_cnt++;
		conclude;
	end
	initial
	begin
		repeat (10) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		for (int i = 0; i < 8; i++) rd(ra[i], re[i]);
		wr(8'h00, 8'he7);
		rd(8'h00, 8'h27);
		wr(8'h01, 8'ha5);
		wr(8'h02, 8'h5a);
		wr(8'h03, 8'hc3);
		repeat (2) @(posedge mclk);
		chk("red code", 10'h30e, rc);
		chk("green code", 10'h297, gc);
		chk("blue code", 10'h169, bc);
		wr(8'h05, 8'hfe);
		rd(8'h05, 8'h00);
		wr(8'h06, 8'h00);
		rd(8'h06, 8'h24);
		for (int c = 0; c < 4; c++)
		begin
			k[0] = c;
			k[1] = 3 - c;
			k[2] = c ^ 1;
			wr(8'h06, {2'(k[0]), 1'b0, 2'(k[2]), 1'b0, 2'(k[1])});
			fire <= 3'h7;
			@(posedge mclk);
			fire <= 3'h0;
			n = 0;
			seen = '{0, 0, 0};
			while ((seen[0] == 0 || seen[1] == 0 || seen[2] == 0) && n < 4000)
			begin
				for (int i = 0; i < 3; i++)
					if (en_v[i] === 1'b1 && seen[i] == 0)
						seen[i] = n;
				if (seen[0] == 0 || seen[1] == 0 || seen[2] == 0)
				begin
					@(posedge mclk);
					n++;
				end
			end
			repeat (HI + 50 - n) @(posedge mclk);
			for (int i = 0; i < 3; i++)
			begin
				ex = 500 + 1000 * k[i];
				n_tests++;
				if (seen[i] < ex || seen[i] > ex + 12)
				begin
					$display("MISMATCH delay of channel %0d expected %0d seen %0d", i, ex, seen[i]);
					error_cnt++;
				end
			end
		end
		wr(8'h05, 8'h01);
		open_s <= 3'h5;
		short_s <= 3'h6;
		repeat (2) pulse;
		rd(8'h07, 8'h00);
		pulse;
		rd(8'h07, 8'h5a);
		chk("fault output", 10'h1, {9'h0, fault_out});
		wr(8'h07, 8'hff);
		rd(8'h07, 8'h5a);
		wr(8'h05, 8'h00);
		rd(8'h07, 8'h00);
		chk("fault output", 10'h0, {9'h0, fault_out});
		repeat (3) pulse;
		rd(8'h07, 8'h00);
		chk("fault output", 10'h0, {9'h0, fault_out});
		open_s <= 3'h2;
		short_s <= 3'h1;
		wr(8'h05, 8'h01);
		rd(8'h05, 8'h01);
		repeat (3) pulse;
		rd(8'h07, 8'h81);
		chk("fault output", 10'h1, {9'h0, fault_out});
		conclude;
	end
endmodule
